// ### logic/sram_defs.svh
// Constants for the flow-through burst SRAM access block
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH
`define SRAM_ADDR_W 19
`define SRAM_LANES 4
`define SRAM_BYTE_W 8
`define SRAM_BURST_W 2
`define SRAM_BURST_RST 2'h0
`define SRAM_BURST_STEP 2'h1
`define SRAM_CLK_PERIOD_NS 10
`define SRAM_SLEEP_ENTRY_CYC 2
`define SRAM_SLEEP_RECOVERY_TIME_CYC 2
`define SRAM_ORDER_INTERLEAVED 1'b1
`define SRAM_ORDER_LINEAR 1'b0
`endif

// ### logic/sram_pkg.sv
// Types shared by the burst SRAM access block
`include "sram_defs.svh"
package sram_pkg;
    typedef struct packed {
        logic chip_select_primary_n;
        logic chip_select_expand_hi;
        logic chip_select_expand_n;
    } chip_sel_t;
    typedef struct packed {
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
    } strobe_t;
    typedef struct packed {
        logic global_write_n;
        logic byte_write_gate_n;
        logic [`SRAM_LANES-1:0] byte_lane_select_n;
    } write_ctrl_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10,
        ST_SLEEP = 2'b11
    } cycle_t;
endpackage

// ### logic/sram_mem.sv
// Byte-lane storage array with registered read data
`timescale 1ns/10ps
module sram_mem #(
    parameter int ADDR_W = 19,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    // Clock and enable
    input wire logic clk_in,
    input wire logic en_in,
    // Write port
    input wire logic [LANES-1:0] lane_we_in,
    input wire logic [ADDR_W-1:0] waddr_in,
    input wire logic [LANES*LANE_W-1:0] wdata_in,
    // Read port
    input wire logic [ADDR_W-1:0] raddr_in,
    output logic [LANES*LANE_W-1:0] rdata_q_out
);
    wire [LANES*LANE_W-1:0] rd_all;

    // One storage column per byte lane, each written by its own process
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] lane_q [0:(1<<ADDR_W)-1];
            assign rd_all[g*LANE_W +: LANE_W] = lane_q[raddr_in];
            always_ff @(posedge clk_in) begin
                if (en_in && lane_we_in[g]) begin
                    lane_q[waddr_in] <= wdata_in[g*LANE_W +: LANE_W];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (en_in) begin
            rdata_q_out <= rd_all;
        end
    end
endmodule

// ### logic/sync_burst_sram_access.sv
// Access control of a flow-through synchronous burst SRAM with common data lines
// Operation
// - Strap low linear, high interleaved, held static.
// - Interleaved low bits are start XOR beat.
// - Linear low bits increment by one, wrap.
// - Load two-bit burst counter at burst start.
// - Counter steps only when advance sampled active.
// - All synchronous inputs registered on rising edge.
// - Processor strobe ignored while primary select high.
// - Read starts on strobe with all selects.
// - Read data flows out right after address edge.
// - Processor start is a read; writes follow.
// - Controller strobe with write controls writes immediately.
// - Both strobes low: processor strobe wins.
// - Data and parity tristate on detected write.
// - Byte gate plus lanes; global write writes all.
// - Three chip selects decode; enable drives outputs.
// - Sleep request enters and leaves in two cycles.
// - Accesses pending at sleep entry are dropped.
// - Write when lane and gate low, or global.
// - Active advance moves to next burst address.
// - Outputs tristate while deselected and first clock after.
`timescale 1ns/10ps
`include "sram_defs.svh"
module sync_burst_sram_access
    import sram_pkg::*;
#(
    parameter int ADDR_W = `SRAM_ADDR_W
) (
    // Clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    // Strap and sleep
    input wire logic burst_order_in,
    input wire logic sleep_request_in,
    output logic sleeping_out,
    // Address and controls
    input wire logic [ADDR_W-1:0] addr_in,
    input wire chip_sel_t chip_sel_in,
    input wire strobe_t strobe_in,
    input wire write_ctrl_t write_ctrl_in,
    input wire logic output_enable_n_in,
    // Data lines
    input wire logic [`SRAM_LANES*`SRAM_BYTE_W-1:0] dq_in,
    output logic [`SRAM_LANES*`SRAM_BYTE_W-1:0] dq_out,
    output logic dq_oe_out,
    // Parity lines
    input wire logic [`SRAM_LANES-1:0] parity_lines_in,
    output logic [`SRAM_LANES-1:0] parity_lines_out,
    output logic parity_lines_oe_out
);
    localparam int LANES = `SRAM_LANES;
    localparam int BYTE_W = `SRAM_BYTE_W;
    localparam int LANE_W = BYTE_W + 1;
    localparam int BW = `SRAM_BURST_W;

    cycle_t cyc_q, cyc_d;
    logic order_q;
    logic sleep_meta_q, sleep_q;
    logic [ADDR_W-1:BW] upper_q;
    logic [BW-1:0] start_low_q, count_q;
    logic [ADDR_W-1:0] addr_q;
    logic mask_q;
    logic [LANES*LANE_W-1:0] rdata_q;
    logic [LANES*LANE_W-1:0] wdata;

    // Strobe and select decode
    wire cs_all = !chip_sel_in.chip_select_primary_n && chip_sel_in.chip_select_expand_hi
        && !chip_sel_in.chip_select_expand_n;
    wire proc_strobe = !strobe_in.processor_addr_strobe_n
        && !chip_sel_in.chip_select_primary_n;
    wire ctrl_strobe = !strobe_in.controller_addr_strobe_n && !proc_strobe;
    wire any_strobe = proc_strobe || ctrl_strobe;
    wire start_acc = any_strobe && cs_all && !sleep_q;
    wire desel_acc = any_strobe && !cs_all;
    wire active = (cyc_q == ST_READ) || (cyc_q == ST_WRITE);
    wire cont_acc = !any_strobe && active && !sleep_q;
    wire advance = cont_acc && !strobe_in.burst_advance_n;

    // Write qualification
    wire byte_wr = !write_ctrl_in.byte_write_gate_n && (write_ctrl_in.byte_lane_select_n != '1);
    wire wr_cond = !write_ctrl_in.global_write_n || byte_wr;
    wire [LANES-1:0] lane_mask = !write_ctrl_in.global_write_n ? {LANES{1'b1}} :
        (!write_ctrl_in.byte_write_gate_n ? ~write_ctrl_in.byte_lane_select_n : {LANES{1'b0}});
    wire ctrl_write = start_acc && ctrl_strobe && wr_cond;
    wire cont_write = cont_acc && wr_cond;
    wire wr_now = ctrl_write || cont_write;
    wire [LANES-1:0] lane_we = wr_now ? lane_mask : {LANES{1'b0}};

    // Burst counter and address
    wire [BW-1:0] count_d = start_acc ? `SRAM_BURST_RST :
        (advance ? count_q + `SRAM_BURST_STEP : count_q);
    wire [BW-1:0] start_low_d = start_acc ? addr_in[BW-1:0] : start_low_q;
    wire [BW-1:0] inter_low = start_low_d ^ count_d;
    wire [BW-1:0] lin_low = start_low_d + count_d;
    wire [BW-1:0] low_d = (order_q == `SRAM_ORDER_INTERLEAVED) ? inter_low : lin_low;
    wire [ADDR_W-1:BW] upper_d = start_acc ? addr_in[ADDR_W-1:BW] : upper_q;
    wire [ADDR_W-1:0] addr_d = {upper_d, low_d};

    // Write and read data per lane with its parity bit
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_pack
            assign wdata[g*LANE_W +: LANE_W] = {parity_lines_in[g], dq_in[g*BYTE_W +: BYTE_W]};
            assign dq_out[g*BYTE_W +: BYTE_W] = rdata_q[g*LANE_W +: BYTE_W];
            assign parity_lines_out[g] = rdata_q[g*LANE_W + BYTE_W];
        end
    endgenerate

    // Read data registered at the same edge as the address
    sram_mem #(
        .ADDR_W(ADDR_W),
        .LANES(LANES),
        .LANE_W(LANE_W)
    ) u_mem (
        .clk_in(sys_clk_in),
        .en_in(clk_en_in),
        .lane_we_in(lane_we),
        .waddr_in(addr_d),
        .wdata_in(wdata),
        .raddr_in(addr_d),
        .rdata_q_out(rdata_q)
    );

    // Next cycle kind
    always_comb begin
        cyc_d = cyc_q;
        case (cyc_q)
            ST_SLEEP: begin
                if (!sleep_q) begin
                    cyc_d = start_acc ? (ctrl_write ? ST_WRITE : ST_READ) : ST_IDLE;
                end
            end
            default: begin
                if (sleep_q) begin
                    cyc_d = ST_SLEEP;
                end else if (start_acc) begin
                    cyc_d = ctrl_write ? ST_WRITE : ST_READ;
                end else if (desel_acc) begin
                    cyc_d = ST_IDLE;
                end else if (cont_acc) begin
                    cyc_d = wr_cond ? ST_WRITE : ST_READ;
                end
            end
        endcase
    end

    // Strap capture at reset
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            order_q <= burst_order_in;
        end
    end

    // Sleep request synchroniser
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            sleep_meta_q <= 1'b0;
            sleep_q <= 1'b0;
        end else if (clk_en_in) begin
            sleep_meta_q <= sleep_request_in;
            sleep_q <= sleep_meta_q;
        end
    end

    // Input registers and burst state
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cyc_q <= ST_IDLE;
            upper_q <= '0;
            start_low_q <= `SRAM_BURST_RST;
            count_q <= `SRAM_BURST_RST;
            addr_q <= '0;
            mask_q <= 1'b0;
        end else if (clk_en_in) begin
            cyc_q <= cyc_d;
            upper_q <= upper_d;
            start_low_q <= start_low_d;
            count_q <= count_d;
            addr_q <= addr_d;
            mask_q <= start_acc && !active;
        end
    end

    // Output drive control
    wire wr_seen = cont_write || ctrl_write || (cyc_q == ST_WRITE);
    wire drive = !output_enable_n_in && (cyc_q == ST_READ) && !mask_q && !wr_seen && !sleep_q;
    assign dq_oe_out = drive;
    assign parity_lines_oe_out = drive;
    assign sleeping_out = sleep_q;

    // Checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (srst_in);

    sequence s_sleep_held;
        (clk_en_in && sleep_request_in) ##1 (clk_en_in && sleep_request_in);
    endsequence

    sequence s_leave_idle;
        clk_en_in && start_acc && !active && !ctrl_write;
    endsequence

    sequence s_wake_held;
        (clk_en_in && !sleep_request_in) ##1 (clk_en_in && !sleep_request_in);
    endsequence

    sequence s_proc_start;
        clk_en_in && proc_strobe && cs_all && !sleep_q;
    endsequence

    sequence s_wr_follow;
        clk_en_in && cont_acc && wr_cond;
    endsequence

    chk_strap_static: assert property ($stable(order_q))
        else $error("burst order changed during operation");

    chk_interleave_step: assert property (clk_en_in && advance && order_q
        |=> addr_q[BW-1:0] == (start_low_q ^ count_q) && count_q == $past(count_q) + 2'h1)
        else $error("interleaved burst address wrong");

    chk_linear_step: assert property (clk_en_in && advance && !order_q
        |=> addr_q[BW-1:0] == start_low_q + count_q)
        else $error("linear burst address wrong");

    chk_burst_load: assert property (clk_en_in && start_acc
        |=> addr_q == $past(addr_in) && count_q == 2'h0)
        else $error("burst start address not loaded");

    chk_hold_addr: assert property (clk_en_in && cont_acc && strobe_in.burst_advance_n
        |=> $stable(addr_q) && $stable(count_q))
        else $error("burst address moved without advance");

    chk_proc_ignored: assert property (chip_sel_in.chip_select_primary_n
        && strobe_in.controller_addr_strobe_n |-> !start_acc && !desel_acc)
        else $error("processor strobe acted with primary select high");

    chk_proc_wins: assert property (clk_en_in && proc_strobe && cs_all && !sleep_q
        |-> lane_we == '0 ##1 cyc_q == ST_READ)
        else $error("processor start did not become a read");

    chk_ctrl_write: assert property (clk_en_in && ctrl_strobe && cs_all && wr_cond && !sleep_q
        |-> lane_we == lane_mask ##1 cyc_q == ST_WRITE && !dq_oe_out)
        else $error("controller write not taken");

    chk_write_tristate: assert property (wr_seen |-> !dq_oe_out && !parity_lines_oe_out)
        else $error("data lines driven during a write");

    chk_desel_mask: assert property (s_leave_idle |=> !dq_oe_out)
        else $error("output driven on first clock after deselect");

    chk_sleep_entry: assert property (s_sleep_held |=> sleeping_out ##1 cyc_q == ST_SLEEP)
        else $error("sleep not entered in two cycles");

    chk_sleep_exit: assert property (s_wake_held |=> !sleeping_out)
        else $error("sleep not left in two cycles");

    chk_sleep_no_write: assert property (sleep_q |-> lane_we == '0)
        else $error("write while asleep");

    chk_sleep_quiet: assert property (cyc_q == ST_SLEEP && sleep_q |-> lane_we == '0 && !dq_oe_out)
        else $error("activity while asleep");

    chk_proc_then_write: assert property (s_proc_start ##1 s_wr_follow |-> lane_we == lane_mask)
        else $error("write after processor start not taken");

    chk_ctrl_read: assert property (clk_en_in && ctrl_strobe && cs_all && !wr_cond && !sleep_q
        |-> lane_we == '0 ##1 cyc_q == ST_READ)
        else $error("controller read not taken");

    chk_idle_hold: assert property (clk_en_in && !any_strobe && cyc_q == ST_IDLE && !sleep_q
        |=> cyc_q == ST_IDLE)
        else $error("access started without a strobe");

    chk_desel_idle: assert property (clk_en_in && desel_acc && !sleep_q |=> cyc_q == ST_IDLE && !dq_oe_out)
        else $error("deselect not taken");

    chk_idle_quiet: assert property (cyc_q == ST_IDLE |-> !dq_oe_out)
        else $error("outputs driven while deselected");

    chk_select_decode: assert property (!chip_sel_in.chip_select_expand_hi |-> !start_acc)
        else $error("start with expansion select inactive");

    chk_drive_read: assert property (cyc_q == ST_READ && !mask_q && !output_enable_n_in && !wr_seen
        && !sleep_q |-> dq_oe_out)
        else $error("read data not driven");

    chk_count_hold: assert property (clk_en_in && !advance && !start_acc |=> $stable(count_q))
        else $error("burst counter moved without advance");

    chk_count_wrap: assert property (clk_en_in && advance && count_q == 2'h3 |=> count_q == 2'h0)
        else $error("burst counter did not wrap");

    chk_upper_hold: assert property (clk_en_in && !start_acc |=> $stable(upper_q))
        else $error("upper address moved inside a burst");

    chk_lane_all: assert property (!write_ctrl_in.global_write_n |-> lane_mask == '1)
        else $error("global write missed a lane");

    chk_read_cond: assert property (write_ctrl_in.global_write_n && write_ctrl_in.byte_write_gate_n
        |-> !wr_cond)
        else $error("write seen with gates inactive");
endmodule

// ### bench/bus_master_model.sv
// Bus master model driving the burst SRAM access block
`timescale 1ns/10ps
module bus_master_model
    import sram_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Bus controls
    output logic [5:0] addr_out,
    output chip_sel_t chip_sel_out,
    output strobe_t strobe_out,
    output write_ctrl_t write_ctrl_out,
    output logic output_enable_n_out,
    output logic sleep_request_out,
    // Data and parity
    output logic [35:0] data_out
);
    initial begin
        addr_out = 6'h00;
        chip_sel_out = 3'h5;
        strobe_out = 3'h7;
        write_ctrl_out = 6'h3f;
        output_enable_n_out = 1'b1;
        sleep_request_out = 1'b0;
        data_out = 36'h0_0000_0000;
    end
    // One bus cycle, launched after the falling edge
    task automatic cyc(input logic [2:0] sel, input logic [2:0] stb, input logic [5:0] wc, input logic [5:0] a,
                       input logic [35:0] d);
        @(negedge clk_in);
        chip_sel_out = sel;
        strobe_out = stb;
        write_ctrl_out = wc;
        addr_out = a;
        if (wc != 6'h3f) begin
            output_enable_n_out = 1'b1;
            #2;
            data_out = d;
        end else begin
            data_out = ~data_out;
            output_enable_n_out = 1'b0;
        end
    endtask
    // Sleep request with the bus kept idle around it
    task automatic nap(input logic on);
        if (on)
            cyc(3'h5, 3'h5, 6'h3f, addr_out, data_out);
        cyc(3'h5, 3'h7, 6'h3f, addr_out, data_out);
        sleep_request_out = on;
    endtask
endmodule

// ### bench/testbench.sv
// Self-checking testbench for the burst SRAM access block
`timescale 1ns/10ps
module testbench
    import sram_pkg::*;
;
    logic clk, srst, ord, oe, poe, sleeping, first, cont;
    logic [5:0] addr, a, base;
    logic [1:0] k;
    chip_sel_t sel;
    strobe_t stb;
    write_ctrl_t wc;
    logic oe_n, sreq;
    logic [35:0] m_data;
    logic [31:0] dq;
    logic [3:0] par;
    logic [35:0] mem [64];
    int failures = 0;
    int compares = 0;
    int st = 0;
    wire logic [31:0] dq_w = oe ? dq : m_data[31:0];
    wire logic [3:0] par_w = poe ? par : m_data[35:32];
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    bus_master_model master (.clk_in(clk), .addr_out(addr), .chip_sel_out(sel), .strobe_out(stb),
        .write_ctrl_out(wc), .output_enable_n_out(oe_n), .sleep_request_out(sreq), .data_out(m_data));
    sync_burst_sram_access #(.ADDR_W(6)) uut (.sys_clk_in(clk), .srst_in(srst), .clk_en_in(1'b1),
        .burst_order_in(ord), .sleep_request_in(sreq), .sleeping_out(sleeping), .addr_in(addr),
        .chip_sel_in(sel), .strobe_in(stb), .write_ctrl_in(wc), .output_enable_n_in(oe_n), .dq_in(dq_w),
        .dq_out(dq), .dq_oe_out(oe), .parity_lines_in(par_w), .parity_lines_out(par), .parity_lines_oe_out(poe));
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [35:0] rnd();
        return 36'({$urandom, $urandom});
    endfunction
    // One cycle on the bus, then the reference model follows it
    task automatic op(input logic [2:0] s, input logic [2:0] b, input logic [5:0] w, input logic [5:0] ad,
                      input logic [35:0] d);
        int prev;
        logic [5:0] ca;
        prev = st;
        master.cyc(s, b, w, ad, d);
        @(posedge clk);
        #1;
        if ((!b[2] && !s[2]) || !b[1]) begin
            first = prev == 0;
            base = ad;
            k = 2'h0;
            st = (s != 3'h2) ? 0 : (b[2] && (!w[5] || (!w[4] && w[3:0] != 4'hf))) ? 2 : 1;
        end else if (st != 0) begin
            first = 1'b0;
            k = k + 2'(!b[0]);
            st = (!w[5] || (!w[4] && w[3:0] != 4'hf)) ? 2 : 1;
        end
        cont = prev == 1 && st == 1 && w == 6'h3f;
        ca = {base[5:2], ord ? base[1:0] ^ k : base[1:0] + k};
        if (st == 2) begin
            for (int g = 0; g < 4; g++)
                if (!w[5] || (!w[4] && !w[g])) begin
                    mem[ca][8*g+:8] = d[8*g+:8];
                    mem[ca][32+g] = d[32+g];
                end
            chk("write oe", 36'h0_0000_0000, 36'({oe, poe}));
        end
        if (st == 0)
            chk("desel oe", 36'h0_0000_0000, 36'({oe, poe}));
        if (st == 1) begin
            chk("read data", mem[ca], {par, dq});
            if (first || cont)
                chk("read oe", 36'({cont, cont}), 36'({oe, poe}));
        end
    endtask
    initial begin
        #50000;
        failures++;
        complete_run;
    end
    initial begin
        srst = 1'b1;
        ord = 1'b0;
        void'($urandom(32'h5a9fbcd4));
        for (int o = 0; o < 2; o++) begin
            @(negedge clk);
            srst = 1'b1;
            ord = o[0];
            st = 0;
            repeat (5) @(negedge clk);
            srst = 1'b0;
            for (int i = 0; i < 64; i++)
                op(3'h2, 3'h5, 6'h1f, i[5:0], rnd());
            $display("test fill done");
            a = 6'($urandom);
            op(3'h2, 3'h3, 6'h3f, a, 0);
            repeat (4) op(3'h2, 3'h6, 6'h3f, a, 0);
            op(3'h2, 3'h7, 6'h3f, a, 0);
            op(3'h6, 3'h2, 6'h3f, a, 0);
            $display("test burst done");
            op(3'h2, 3'h3, 6'h20, a, rnd());
            op(3'h2, 3'h7, {2'h2, 4'($urandom)}, a, rnd());
            op(3'h2, 3'h6, 6'h3f, a, 0);
            op(3'h2, 3'h1, 6'h1f, a, rnd());
            op(3'h2, 3'h7, 6'h30, a, rnd());
            op(3'h0, 3'h5, 6'h1f, a, rnd());
            op(3'h3, 3'h5, 6'h1f, a, rnd());
            op(3'h2, 3'h3, 6'h3f, a, 0);
            $display("test write done");
            master.nap(1'b1);
            for (int i = 0; i < 4; i++) begin
                if (i == 2)
                    master.nap(1'b0);
                @(posedge clk);
                #1;
                chk("sleeping", 36'(i == 1 || i == 2), 36'(sleeping));
            end
            st = 0;
            op(3'h2, 3'h3, 6'h3f, a, 0);
            $display("test sleep done");
        end
        complete_run;
    end
endmodule
